/* pmic_regs_consts.svh */
// constants for the sleep/wake, identification and protection status registers
// assumes one 250 MHz system clock and an open-drain two-wire serial port
`ifndef PMIC_REGS_CONSTS_SVH
`define PMIC_REGS_CONSTS_SVH

// register offsets
`define OFS_RAIL3_LINEAR_CFG 8'h06
`define OFS_XEN_CFG 8'h07
`define OFS_PART_CODE 8'h0A
`define OFS_MAKER_ID 8'h0B
`define OFS_SILICON_REV 8'h0C
`define OFS_PROT_STATUS 8'h0D

// reset values of the writable registers
`define RST_RAIL3_LINEAR_CFG 8'hE1
`define RST_XEN_CFG 8'h8A

// field positions, shared by both wake/sleep registers
`define FLD_HI_SLOT_MSB 7
`define FLD_HI_SLOT_LSB 5
`define FLD_HI_KEEPON 4
`define FLD_LO_SLOT_MSB 3
`define FLD_LO_SLOT_LSB 1
`define FLD_LO_KEEPON 0

// identification values, arbitrary
`define PART_CODE_DEF 8'h5C
`define MAKER_CODE_DEF 8'hA3
`define SILICON_REV_DEF 8'h01
// serial device address, arbitrary
`define DEV_ADDR_DEF 7'h2D

// wake timing
`define CLK_PERIOD_NS 4
`define WAKE_BASE_US 150
`define WAKE_STEP_US 512
`define WAKE_BASE_CYC ((`WAKE_BASE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_STEP_CYC ((`WAKE_STEP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CNT_W 20

// synchroniser reset: clock, data and standby pins idle high
`define SYNC_RST 11'h700

`endif

/* pmic_regs_pkg.sv */
// types for the sleep/wake, identification and protection status registers
// assumes the constants header is on the include path
package pmic_regs_pkg;
  typedef logic [2:0] wake_slot_t;
  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_PTR,
    S_PTR_ACK,
    S_WDAT,
    S_WDAT_ACK,
    S_RDAT,
    S_RDAT_ACK
  } ser_state_t;
endpackage

/* pmic_sleep_wake_id_status_regs.sv */
// sleep/wake configuration, identification and protection status registers
// behind the two-wire serial port, plus the four sleep-aware enable outputs
// assumes pins are asynchronous to clk_sys_i and the serial clock is far slower
//
// How it works
// - In sleep the third buck enable drops unless its keep-on bit 4 of the rail3/linear register is 1.
// - In sleep the linear regulator enable drops unless bit 0 of the rail3/linear register is 1.
// - In sleep external enable A drops unless bit 4 of the external-enable register is 1.
// - In sleep external enable B drops unless bit 0 of the external-enable register is 1.
// - The rail3/linear register holds the buck3 wake slot in bits 7:5 and the linear one in 3:1.
// - The external-enable register holds the A wake slot in bits 7:5 and the B one in 3:1.
// - A rail with wake slot N rises 150 us plus N times 512 us after the wake request.
// - The product identification register reads a fixed 8-bit part code.
// - The maker identification register reads a fixed 8-bit maker code.
// - The silicon revision register reads a fixed 8-bit revision code.
// - Protection status bits 7 to 4 report under-voltage of buck 1, 2, 3 and the linear rail.
// - Protection status bit 3 reports over-temperature.
// - Protection status bit 2 reports input over-voltage.
// - Protection status bits 1 and 0 show the gate-ready and output power-on monitors.
`include "pmic_regs_consts.svh"
module pmic_sleep_wake_id_status_regs #(
  parameter int unsigned WAKE_BASE_CYC = `WAKE_BASE_CYC,
  parameter int unsigned WAKE_STEP_CYC = `WAKE_STEP_CYC,
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEF,
  parameter logic [7:0] PART_CODE = `PART_CODE_DEF,
  parameter logic [7:0] MAKER_CODE = `MAKER_CODE_DEF,
  parameter logic [7:0] SILICON_REV = `SILICON_REV_DEF
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // serial port, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o_o,
  output logic sda_oe_o,
  // power state request
  input wire logic standby_n_i,
  // protection monitors
  input wire logic buck1_undervolt_flag_i,
  input wire logic buck2_undervolt_flag_i,
  input wire logic buck3_undervolt_flag_i,
  input wire logic linreg_undervolt_flag_i,
  input wire logic overtemp_flag_i,
  input wire logic input_overvolt_flag_i,
  input wire logic gate_ready_monitor_i,
  input wire logic output_por_monitor_i,
  // rail and external enables
  output logic buck3_en_o,
  output logic linreg_en_o,
  output logic external_enable_a_o,
  output logic external_enable_b_o
);
  import pmic_regs_pkg::*;

  logic [10:0] pin_meta_q;
  logic [10:0] pin_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_s;
  logic sda_s;
  logic sleep;
  logic [7:0] prot_status;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  ser_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic nack_q;
  logic wr_stb;
  logic [7:0] rd_data;
  logic rd_reload_q;
  logic [7:0] rail3_linear_wake_sleep_cfg_q;
  logic [7:0] external_enable_wake_sleep_cfg_q;
  logic [3:0] keepon;
  wake_slot_t slot [4];
  logic [3:0] en;

  // two-stage synchroniser for every pin
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta_q <= `SYNC_RST;
      pin_sync_q <= `SYNC_RST;
    end else begin
      pin_meta_q <= {scl_i, sda_i, standby_n_i, buck1_undervolt_flag_i,
                     buck2_undervolt_flag_i, buck3_undervolt_flag_i,
                     linreg_undervolt_flag_i, overtemp_flag_i, input_overvolt_flag_i,
                     gate_ready_monitor_i, output_por_monitor_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_s = pin_sync_q[10];
  assign sda_s = pin_sync_q[9];
  assign sleep = !pin_sync_q[8];
  assign prot_status = pin_sync_q[7:0];

  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // read mux, unmapped offsets read zero
  always_comb begin
    unique case (ptr_q)
      `OFS_RAIL3_LINEAR_CFG: rd_data = rail3_linear_wake_sleep_cfg_q;
      `OFS_XEN_CFG: rd_data = external_enable_wake_sleep_cfg_q;
      `OFS_PART_CODE: rd_data = PART_CODE;
      `OFS_MAKER_ID: rd_data = MAKER_CODE;
      `OFS_SILICON_REV: rd_data = SILICON_REV;
      `OFS_PROT_STATUS: rd_data = prot_status;
      default: rd_data = 8'h00;
    endcase
  end

  assign wr_stb = scl_fall && state_q == S_WDAT && bit_cnt_q == 4'h8;

  // serial protocol engine
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= S_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (start_cond) begin
      state_q <= S_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (stop_cond) begin
      state_q <= S_IDLE;
      sda_oe_o <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_q)
        S_ADDR, S_PTR, S_WDAT: begin
          shift_q <= {shift_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        S_RDAT: bit_cnt_q <= bit_cnt_q + 4'h1;
        S_RDAT_ACK: nack_q <= sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        S_IDLE: ;
        S_ADDR: begin
          if (bit_cnt_q == 4'h8) begin
            if (shift_q[7:1] == DEV_ADDR) begin
              rw_q <= shift_q[0];
              state_q <= S_ADDR_ACK;
              sda_oe_o <= 1'b1;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          bit_cnt_q <= 4'h0;
          if (rw_q) begin
            state_q <= S_RDAT;
            sda_oe_o <= !rd_data[7];
            tx_q <= {rd_data[6:0], 1'b0};
          end else begin
            state_q <= S_PTR;
            sda_oe_o <= 1'b0;
          end
        end
        S_PTR: begin
          if (bit_cnt_q == 4'h8) begin
            ptr_q <= shift_q;
            state_q <= S_PTR_ACK;
            sda_oe_o <= 1'b1;
          end
        end
        S_PTR_ACK, S_WDAT_ACK: begin
          if (state_q == S_WDAT_ACK) begin
            ptr_q <= ptr_q + 8'h01;
          end
          state_q <= S_WDAT;
          bit_cnt_q <= 4'h0;
          sda_oe_o <= 1'b0;
        end
        S_WDAT: begin
          if (bit_cnt_q == 4'h8) begin
            state_q <= S_WDAT_ACK;
            sda_oe_o <= 1'b1;
          end
        end
        S_RDAT: begin
          if (bit_cnt_q == 4'h8) begin
            state_q <= S_RDAT_ACK;
            sda_oe_o <= 1'b0;
          end else begin
            sda_oe_o <= !tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        S_RDAT_ACK: begin
          if (nack_q) begin
            state_q <= S_IDLE;
          end else begin
            state_q <= S_RDAT;
            bit_cnt_q <= 4'h0;
            ptr_q <= ptr_q + 8'h01;
          end
        end
      endcase
    end else if (rd_reload_q && state_q == S_RDAT) begin
      // burst read: pointer has stepped, drive msb of the next byte
      sda_oe_o <= !rd_data[7];
      tx_q <= {rd_data[6:0], 1'b0};
    end
  end

  // next read byte is loaded one cycle after the pointer steps
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_reload_q <= 1'b0;
    end else begin
      rd_reload_q <= scl_fall && state_q == S_RDAT_ACK && !nack_q && !start_cond &&
                     !stop_cond;
    end
  end

  // open drain: data line only ever pulled low
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_o_o <= 1'b0;
    end else begin
      sda_o_o <= 1'b0;
    end
  end

  // writable wake/sleep registers; other offsets ignore writes
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rail3_linear_wake_sleep_cfg_q <= `RST_RAIL3_LINEAR_CFG;
      external_enable_wake_sleep_cfg_q <= `RST_XEN_CFG;
    end else if (wr_stb) begin
      if (ptr_q == `OFS_RAIL3_LINEAR_CFG) begin
        rail3_linear_wake_sleep_cfg_q <= shift_q;
      end
      if (ptr_q == `OFS_XEN_CFG) begin
        external_enable_wake_sleep_cfg_q <= shift_q;
      end
    end
  end

  assign keepon[0] = rail3_linear_wake_sleep_cfg_q[`FLD_HI_KEEPON];
  assign keepon[1] = rail3_linear_wake_sleep_cfg_q[`FLD_LO_KEEPON];
  assign keepon[2] = external_enable_wake_sleep_cfg_q[`FLD_HI_KEEPON];
  assign keepon[3] = external_enable_wake_sleep_cfg_q[`FLD_LO_KEEPON];
  assign slot[0] = rail3_linear_wake_sleep_cfg_q[`FLD_HI_SLOT_MSB:`FLD_HI_SLOT_LSB];
  assign slot[1] = rail3_linear_wake_sleep_cfg_q[`FLD_LO_SLOT_MSB:`FLD_LO_SLOT_LSB];
  assign slot[2] = external_enable_wake_sleep_cfg_q[`FLD_HI_SLOT_MSB:`FLD_HI_SLOT_LSB];
  assign slot[3] = external_enable_wake_sleep_cfg_q[`FLD_LO_SLOT_MSB:`FLD_LO_SLOT_LSB];

  for (genvar g = 0; g < 4; g++) begin : g_out
    wake_slot_timer #(
      .BASE_CYC(WAKE_BASE_CYC),
      .STEP_CYC(WAKE_STEP_CYC)
    ) u_timer (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .sleep_i(sleep),
      .keepon_i(keepon[g]),
      .slot_i(slot[g]),
      .en_o(en[g])
    );
  end

  assign buck3_en_o = en[0];
  assign linreg_en_o = en[1];
  assign external_enable_a_o = en[2];
  assign external_enable_b_o = en[3];

  a_buck3_sleep_off: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    sleep && !keepon[0] |=> !buck3_en_o)
    else $error("third buck stayed on in sleep without keep-on");

  a_linreg_sleep_keep: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    sleep && keepon[1] && linreg_en_o |=> linreg_en_o)
    else $error("linear regulator dropped in sleep with keep-on set");

  a_linreg_sleep_off: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    sleep && !keepon[1] |=> !linreg_en_o)
    else $error("linear regulator stayed on in sleep without keep-on");

  a_xen_a_sleep: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    sleep |=> external_enable_a_o == ($past(external_enable_a_o) && $past(keepon[2])))
    else $error("external enable A wrong in sleep");

  a_xen_b_sleep: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    sleep |=> external_enable_b_o == ($past(external_enable_b_o) && $past(keepon[3])))
    else $error("external enable B wrong in sleep");

  a_cfg_write_take: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    wr_stb && (ptr_q == `OFS_RAIL3_LINEAR_CFG || ptr_q == `OFS_XEN_CFG) |=>
    rd_data == $past(shift_q) || ptr_q != $past(ptr_q))
    else $error("wake/sleep register did not take the written byte");

  a_part_code_read: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    ptr_q == `OFS_PART_CODE |-> rd_data == PART_CODE)
    else $error("product identification read wrong");

  a_maker_code_read: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    ptr_q == `OFS_MAKER_ID |-> rd_data == MAKER_CODE)
    else $error("maker identification read wrong");

  a_revision_read: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    ptr_q == `OFS_SILICON_REV |-> rd_data == SILICON_REV)
    else $error("silicon revision read wrong");

  a_prot_status_read: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    ptr_q == `OFS_PROT_STATUS |->
    rd_data == $past({buck1_undervolt_flag_i, buck2_undervolt_flag_i, buck3_undervolt_flag_i,
                      linreg_undervolt_flag_i, overtemp_flag_i, input_overvolt_flag_i,
                      gate_ready_monitor_i, output_por_monitor_i}, 2))
    else $error("protection status read wrong");

  a_ro_write_ignored: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    wr_stb && ptr_q != `OFS_RAIL3_LINEAR_CFG && ptr_q != `OFS_XEN_CFG |=>
    $stable(rail3_linear_wake_sleep_cfg_q) && $stable(external_enable_wake_sleep_cfg_q))
    else $error("write to a read-only offset changed a register");
endmodule

/* ssd_host_model.sv */
// host controller model: two-wire serial master plus the standby request pin
// assumes a pull-up on the data line and the same system clock as the device
module ssd_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2D
) (
  // clock
  input wire logic clk_sys_i,
  // serial port
  input wire logic dev_sda_oe_i,
  output logic scl_o,
  output logic sda_o,
  // power state request
  output logic standby_n_o
);
  logic pull_q;

  initial begin
    scl_o = 1'b1;
    pull_q = 1'b0;
    standby_n_o = 1'b1;
  end

  // wired-and line, pulled up when nobody pulls it down
  assign sda_o = !(pull_q || dev_sda_oe_i);

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // start, or repeated start from a low clock
  task automatic start_cond();
    pull_q <= 1'b0;
    hold(5);
    scl_o <= 1'b1;
    hold(10);
    pull_q <= 1'b1;
    hold(10);
    scl_o <= 1'b0;
    hold(5);
  endtask

  task automatic stop_cond();
    pull_q <= 1'b1;
    hold(5);
    scl_o <= 1'b1;
    hold(10);
    pull_q <= 1'b0;
    hold(10);
  endtask

  // one bit out, the wire level sampled mid high phase
  task automatic clock_bit(input logic b, output logic seen);
    pull_q <= !b;
    hold(5);
    scl_o <= 1'b1;
    hold(5);
    seen = sda_o;
    hold(5);
    scl_o <= 1'b0;
    hold(5);
  endtask

  // eight bits msb first, then the ninth bit; tx all ones reads
  task automatic xfer_byte(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                           output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(tx[i], rx[i]);
    end
    clock_bit(last, ack);
  endtask

  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] dat, output logic nak);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer_byte(ofs, 1'b1, rx, a1);
    xfer_byte(dat, 1'b1, rx, a2);
    stop_cond();
    nak = a0 | a1 | a2;
  endtask

  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] dat);
    logic [7:0] rx;
    logic a;
    start_cond();
    xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a);
    xfer_byte(ofs, 1'b1, rx, a);
    start_cond();
    xfer_byte({DEV_ADDR, 1'b1}, 1'b1, rx, a);
    xfer_byte(8'hFF, 1'b1, dat, a);
    stop_cond();
  endtask

  // two data bytes in one write, pointer steps after the first
  task automatic wr_pair(input logic [7:0] ofs, input logic [7:0] d0, input logic [7:0] d1,
                         output logic nak);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start_cond();
    xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer_byte(ofs, 1'b1, rx, a1);
    xfer_byte(d0, 1'b1, rx, a2);
    xfer_byte(d1, 1'b1, rx, a3);
    stop_cond();
    nak = a0 | a1 | a2 | a3;
  endtask

  // two-byte read: master acks the first byte, nacks the second
  task automatic rd_pair(input logic [7:0] ofs, output logic [7:0] d0,
                         output logic [7:0] d1);
    logic [7:0] rx;
    logic a;
    start_cond();
    xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a);
    xfer_byte(ofs, 1'b1, rx, a);
    start_cond();
    xfer_byte({DEV_ADDR, 1'b1}, 1'b1, rx, a);
    xfer_byte(8'hFF, 1'b0, d0, a);
    xfer_byte(8'hFF, 1'b1, d1, a);
    stop_cond();
  endtask

  task automatic set_standby(input logic lvl);
    @(posedge clk_sys_i);
    standby_n_o <= lvl;
  endtask
endmodule

/* tb_top.sv */
// self-checking bench for the sleep/wake, identification and status registers
// assumes the host model file and the design files are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] DEV = 7'h2D;
  // identification values, arbitrary
  localparam logic [7:0] PART_V = 8'h6E;
  localparam logic [7:0] MAKER_V = 8'h3B;
  localparam logic [7:0] REV_V = 8'h07;
  localparam int BASE = 10;
  localparam int STEP = 20;

  typedef struct packed {
    logic [7:0] ofs;
    logic wr;
    logic [7:0] wdat;
    logic [7:0] exp;
  } row_t;

  logic clk_sys_i;
  logic resetn_i;
  logic scl;
  logic sda;
  logic sda_o_o;
  logic sda_oe_o;
  logic standby_n;
  logic [7:0] prot;
  wire [3:0] en;
  int bad_count;
  int checks;
  row_t rows [11] = '{
    '{8'h06, 1'b0, 8'h00, 8'hE1}, '{8'h07, 1'b0, 8'h00, 8'h8A},
    '{8'h0A, 1'b0, 8'h00, PART_V}, '{8'h0B, 1'b0, 8'h00, MAKER_V},
    '{8'h0C, 1'b0, 8'h00, REV_V}, '{8'h0A, 1'b1, 8'hFF, PART_V},
    '{8'h0B, 1'b1, 8'h00, MAKER_V}, '{8'h0C, 1'b1, 8'h5A, REV_V},
    '{8'h0E, 1'b0, 8'h00, 8'h00}, '{8'h06, 1'b1, 8'hB4, 8'hB4},
    '{8'h07, 1'b1, 8'h6B, 8'h6B}};
  logic [7:0] slp [2][2] = '{'{8'h1C, 8'hE3}, '{8'h85, 8'h70}};

  pmic_sleep_wake_id_status_regs #(
    .WAKE_BASE_CYC(BASE), .WAKE_STEP_CYC(STEP), .DEV_ADDR(DEV),
    .PART_CODE(PART_V), .MAKER_CODE(MAKER_V), .SILICON_REV(REV_V)
  ) dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
    .sda_o_o(sda_o_o), .sda_oe_o(sda_oe_o), .standby_n_i(standby_n),
    .buck1_undervolt_flag_i(prot[7]), .buck2_undervolt_flag_i(prot[6]),
    .buck3_undervolt_flag_i(prot[5]), .linreg_undervolt_flag_i(prot[4]),
    .overtemp_flag_i(prot[3]), .input_overvolt_flag_i(prot[2]),
    .gate_ready_monitor_i(prot[1]), .output_por_monitor_i(prot[0]),
    .buck3_en_o(en[3]), .linreg_en_o(en[2]),
    .external_enable_a_o(en[1]), .external_enable_b_o(en[0])
  );

  ssd_host_model #(.DEV_ADDR(DEV)) host (
    .clk_sys_i(clk_sys_i), .dev_sda_oe_i(sda_oe_o), .scl_o(scl), .sda_o(sda),
    .standby_n_o(standby_n)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] rd;
    logic [7:0] rd2;
    logic nak;
    logic [3:0] keep;
    logic [11:0] slots;
    int t [4];
    int tgt;
    resetn_i = 1'b0;
    prot = 8'h00;
    bad_count = 0;
    checks = 0;
    repeat (3) @(posedge clk_sys_i);
    check("enables in reset", {4'h0, en}, 8'h00);
    check("data drive in reset", {7'h0, sda_oe_o}, 8'h00);
    resetn_i <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    check("enables after power-up", {4'h0, en}, 8'h0F);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        host.wr_reg(rows[i].ofs, rows[i].wdat, nak);
        check("write ack", {7'h0, nak}, 8'h00);
      end
      host.rd_reg(rows[i].ofs, rd);
      check("register read", rd, rows[i].exp);
    end
    // bursts: pointer steps after each written and each acked byte
    host.wr_pair(8'h06, 8'h52, 8'hC9, nak);
    check("burst write ack", {7'h0, nak}, 8'h00);
    host.rd_pair(8'h06, rd, rd2);
    check("burst first byte", rd, 8'h52);
    check("burst second byte", rd2, 8'hC9);
    check("data value", {7'h0, sda_o_o}, 8'h00);
    // walking flag, with an ignored write of all ones each time
    for (int i = 0; i < 8; i++) begin
      prot <= 8'h80 >> i;
      host.wr_reg(8'h0D, 8'hFF, nak);
      host.rd_reg(8'h0D, rd);
      check("protection status", rd, 8'h80 >> i);
    end
    for (int r = 0; r < 2; r++) begin
      host.wr_reg(8'h06, slp[r][0], nak);
      host.wr_reg(8'h07, slp[r][1], nak);
      keep = {slp[r][0][4], slp[r][0][0], slp[r][1][4], slp[r][1][0]};
      slots = {slp[r][0][7:5], slp[r][0][3:1], slp[r][1][7:5], slp[r][1][3:1]};
      host.set_standby(1'b0);
      repeat (200) @(posedge clk_sys_i);
      check("sleep enables", {4'h0, en}, {4'h0, keep});
      t = '{default: 0};
      host.set_standby(1'b1);
      for (int c = 1; c <= 300; c++) begin
        @(posedge clk_sys_i);
        #1;
        for (int k = 0; k < 4; k++) begin
          if (en[k] === 1'b1 && t[k] == 0) begin
            t[k] = c;
          end
        end
      end
      // two sync cycles plus target plus one, one cycle of slack
      for (int k = 0; k < 4; k++) begin
        if (!keep[k]) begin
          tgt = BASE + int'(slots[3*k +: 3]) * STEP + 3;
          check("wake delay", {7'h0, t[k] >= tgt - 1 && t[k] <= tgt + 1}, 8'h01);
        end
      end
    end
    host.start_cond();
    host.xfer_byte({7'h2C, 1'b0}, 1'b1, rd, nak);
    host.stop_cond();
    check("foreign address ack", {7'h0, nak}, 8'h01);
    // second reset in mid-run
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    check("enables in reset", {4'h0, en}, 8'h00);
    resetn_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    host.rd_reg(8'h06, rd);
    check("config after reset", rd, 8'hE1);
    finish_test();
  end

  initial begin
    repeat (80000) @(posedge clk_sys_i);
    bad_count++;
    finish_test();
  end
endmodule

/* wake_slot_timer.sv */
// one rail or enable output: sleep keep-on and slotted wake-up delay
// assumes sleep_i, keepon_i and slot_i are already in the system clock domain
`include "pmic_regs_consts.svh"
module wake_slot_timer #(
  parameter int unsigned BASE_CYC = 1,
  parameter int unsigned STEP_CYC = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // control
  input wire logic sleep_i,
  input wire logic keepon_i,
  input wire pmic_regs_pkg::wake_slot_t slot_i,
  // enable
  output logic en_o
);
  import pmic_regs_pkg::*;
  localparam int CW = `WAKE_CNT_W;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] target;

  assign target = CW'(BASE_CYC + 32'(slot_i) * STEP_CYC);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (sleep_i) begin
      cnt_q <= '0;
    end else if (!en_o && cnt_q != target) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_o <= 1'b0;
    end else if (sleep_i) begin
      en_o <= en_o & keepon_i;
    end else if (cnt_q == target) begin
      en_o <= 1'b1;
    end
  end

  a_wake_rise_time: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(en_o) |-> !$past(sleep_i) && $past(cnt_q) == $past(target))
    else $error("enable rose before its wake slot delay");

  a_wake_count_run: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !sleep_i && !en_o && cnt_q != target ##1 !sleep_i |-> cnt_q == $past(cnt_q) + CW'(1))
    else $error("wake delay counter stalled");
endmodule
